// file: hdl/rdg_pkg.sv
// constants for the runtime disable and pin 1.0 register slice
// assumes a single 50 MHz clock and an AHB-Lite master in front
package rdg_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MIRROR = 8'h21;
  localparam logic [7:0] IDX_DIS = 8'h22;
  localparam logic [7:0] IDX_PIN_CFG = 8'h23;
  localparam logic [7:0] IDX_PIN_DATA = 8'h30;
  localparam logic [9:0] ADDR_MIRROR = {IDX_MIRROR, 2'b00};
  localparam logic [9:0] ADDR_DIS = {IDX_DIS, 2'b00};
  localparam logic [9:0] ADDR_PIN_CFG = {IDX_PIN_CFG, 2'b00};
  localparam logic [9:0] ADDR_PIN_DATA = {IDX_PIN_DATA, 2'b00};
  // writable bit masks
  localparam logic [7:0] MIRROR_MASK = 8'hCF;
  localparam logic [7:0] DIS_MASK = 8'hF9;
  localparam logic [7:0] PIN_CFG_MASK = 8'h87;
  // reset values
  localparam logic [7:0] MIRROR_RST = 8'h00;
  localparam logic [7:0] DIS_RST = 8'h00;
  localparam logic [7:0] PIN_CFG_RST = 8'h01;
  // field positions
  localparam int DIS_WP_BIT = 0;
  localparam int DIS_FN_LSB = 3;
  localparam int PIN_DIR_BIT = 0;
  localparam int PIN_POL_BIT = 1;
  localparam int PIN_ALT_BIT = 2;
  localparam int PIN_OD_BIT = 7;
  // lock field value that hands control to the lock pin
  localparam logic [1:0] LOCK_FIELD = 2'b01;
  // number of functions under the disable override
  localparam int N_FN = 5;
  // ahb transfer type active bit, set for both nonsequential and sequential
  localparam int HTRANS_ACT_BIT = 1;
endpackage : rdg_pkg

// file: hdl/rdg_regs.sv
// runtime disable, fifo control mirror and pin 1.0 configuration
// assumes one clock, ahb-lite slave on a single-slave bus, and pins
// arriving asynchronously; activate and lock field come from logic
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module rdg_regs
  import rdg_pkg::*;
(
  // clock and standby power-on reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // second serial port fifo control capture
  input wire logic fcr_load_i,
  input wire logic [7:0] fcr_data_i,
  // lock control
  input wire logic [1:0] lock_cfg_i,
  input wire logic lock_control_pin_i,
  // function enables: floppy, midi, serial two, serial one, parallel
  input wire logic [rdg_pkg::N_FN-1:0] activate_i,
  output logic [rdg_pkg::N_FN-1:0] fn_enable_o,
  // floppy write protect
  input wire logic force_wp_i,
  input wire logic drive_select0_n_i,
  input wire logic drive_select1_n_i,
  input wire logic write_protect_n_i,
  output logic wrprot_core_o,
  // general pin 1.0
  input wire logic general_pin_1_0_i,
  output logic general_pin_1_0_o,
  output logic general_pin_1_0_oe_n_o,
  output logic joystick1_button1_o
);
  import rdg_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic lock_s;
  logic wp_n_s;
  logic ds0_n_s;
  logic ds1_n_s;
  logic pin_s;

  // two stages; only the second is read anywhere
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1_q <= 5'h1E;
      sync2_q <= 5'h1E;
    end
    else
    begin
      sync1_q <= {general_pin_1_0_i, drive_select1_n_i,
                  drive_select0_n_i, write_protect_n_i,
                  lock_control_pin_i};
      sync2_q <= sync1_q;
    end
  end

  assign lock_s = sync2_q[0];
  assign wp_n_s = sync2_q[1];
  assign ds0_n_s = sync2_q[2];
  assign ds1_n_s = sync2_q[3];
  assign pin_s = sync2_q[4];

  // ----------------------------------------------------------------
  // ahb-lite address and data phase
  // ----------------------------------------------------------------
  logic addr_take;
  logic wr_pend_q;
  logic [9:0] waddr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic [9:0] raddr;

  // only the low ten address bits decode; upper bits alias
  assign addr_take = hsel_i && htrans_i[HTRANS_ACT_BIT] && hready_i;
  assign raddr = haddr_i[9:0];

  // write address held into the data phase
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_pend_q <= 1'b0;
      waddr_q <= 10'h000;
    end
    else if (hready_i)
    begin
      wr_pend_q <= addr_take && hwrite_i;
      waddr_q <= raddr;
    end
  end

  // never stalls, never errors
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
    else
    begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  assign hreadyout_o = hreadyout_q;
  assign hresp_o = hresp_q;

  // ----------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------
  logic [7:0] mirror_q;
  logic [7:0] mirror_d;
  logic [7:0] dis_q;
  logic [7:0] dis_d;
  logic [7:0] pcfg_q;
  logic [7:0] pcfg_d;
  logic pdata_q;
  logic pdata_d;
  logic unlocked;

  // lock pin only matters when the lock field selects it
  assign unlocked = (lock_cfg_i != LOCK_FIELD) || !lock_s;

  // mirror follows the serial core only; bus writes never reach it
  always_comb
  begin
    mirror_d = mirror_q;
    if (fcr_load_i)
      mirror_d = fcr_data_i & MIRROR_MASK;
  end

  // disable register, reserved bits forced to zero
  always_comb
  begin
    dis_d = dis_q;
    if (wr_pend_q && waddr_q == ADDR_DIS && unlocked)
      dis_d = hwdata_i[7:0] & DIS_MASK;
  end

  // pin configuration and output data bit
  always_comb
  begin
    pcfg_d = pcfg_q;
    pdata_d = pdata_q;
    if (wr_pend_q && waddr_q == ADDR_PIN_CFG)
      pcfg_d = hwdata_i[7:0] & PIN_CFG_MASK;
    if (wr_pend_q && waddr_q == ADDR_PIN_DATA)
      pdata_d = hwdata_i[0];
  end

  // storage, all on the standby reset
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mirror_q <= MIRROR_RST;
      dis_q <= DIS_RST;
      pcfg_q <= PIN_CFG_RST;
      pdata_q <= 1'b0;
    end
    else
    begin
      mirror_q <= mirror_d;
      dis_q <= dis_d;
      pcfg_q <= pcfg_d;
      pdata_q <= pdata_d;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;

  // reads see next values, so a read right behind a write is fresh;
  // pin data reads the synchronised pin after polarity
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (raddr)
      ADDR_MIRROR: rd_byte = mirror_d;
      ADDR_DIS: rd_byte = dis_d;
      ADDR_PIN_CFG: rd_byte = pcfg_d;
      ADDR_PIN_DATA: rd_byte = {7'h00, pin_s ^ pcfg_d[PIN_POL_BIT]};
      default: rd_byte = 8'h00;
    endcase
  end

  // data captured at the address phase edge, held to the next read
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      hrdata_q <= 32'h0000_0000;
    else if (addr_take && !hwrite_i)
      hrdata_q <= {24'h00_0000, rd_byte};
  end

  assign hrdata_o = hrdata_q;

  // ----------------------------------------------------------------
  // function enables and write protect
  // ----------------------------------------------------------------
  logic [N_FN-1:0] fn_en_q;
  logic wrprot_q;

  // set disable bit beats the activate bit, clear leaves it alone
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      fn_en_q <= '0;
    else
      fn_en_q <= activate_i & ~dis_q[DIS_FN_LSB +: N_FN];
  end

  // bit 0 floppy, 1 midi, 2 serial two, 3 serial one, 4 parallel
  assign fn_enable_o = fn_en_q;

  // protect term kept exactly as the core expects it
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      wrprot_q <= 1'b0;
    else
      wrprot_q <= (ds0_n_s & force_wp_i) | (ds1_n_s & force_wp_i)
                | wp_n_s | dis_q[DIS_WP_BIT];
  end

  assign wrprot_core_o = wrprot_q;

  // ----------------------------------------------------------------
  // general pin 1.0 driver
  // ----------------------------------------------------------------
  logic pin_out_q;
  logic pin_oe_n_q;
  logic joy_q;
  logic pin_drive;
  logic pin_val;

  // alternate function treats the pin as a button input
  assign pin_drive = !pcfg_q[PIN_DIR_BIT] && !pcfg_q[PIN_ALT_BIT];
  assign pin_val = pdata_q ^ pcfg_q[PIN_POL_BIT];

  // open drain only pulls low; the high level comes from the board
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_out_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end
    else if (!pin_drive)
    begin
      pin_out_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end
    else if (pcfg_q[PIN_OD_BIT])
    begin
      pin_out_q <= 1'b0;
      pin_oe_n_q <= pin_val;
    end
    else
    begin
      pin_out_q <= pin_val;
      pin_oe_n_q <= 1'b0;
    end
  end

  // button idles high when the pin is not routed to the game port
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      joy_q <= 1'b1;
    else if (pcfg_q[PIN_ALT_BIT])
      joy_q <= pin_s ^ pcfg_q[PIN_POL_BIT];
    else
      joy_q <= 1'b1;
  end

  assign general_pin_1_0_o = pin_out_q;
  assign general_pin_1_0_oe_n_o = pin_oe_n_q;
  assign joystick1_button1_o = joy_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  mirror_hold_a: assert property (
    !fcr_load_i |=> $stable(mirror_q))
    else $error("mirror changed without a load");

  mirror_load_a: assert property (
    fcr_load_i |=> mirror_q == ($past(fcr_data_i) & MIRROR_MASK))
    else $error("mirror did not take the fifo control byte");

  lock_hold_a: assert property (
    wr_pend_q && waddr_q == ADDR_DIS && lock_s
    && lock_cfg_i == LOCK_FIELD |=> $stable(dis_q))
    else $error("locked disable register was written");

  unlock_wr_a: assert property (
    wr_pend_q && waddr_q == ADDR_DIS && !(lock_s
    && lock_cfg_i == LOCK_FIELD)
    |=> dis_q == ($past(hwdata_i[7:0]) & DIS_MASK))
    else $error("unlocked disable write lost");

  rsvd_zero_a: assert property (
    dis_q[2:1] == 2'b00 && pcfg_q[6:3] == 4'h0)
    else $error("reserved bits not zero");

  // sampled reset keeps the release edge, still in reset, out of the check
  fn_gate_a: assert property (
    nrst_i |=> fn_enable_o == ($past(activate_i) & ~$past(dis_q[7:3])))
    else $error("function enable not gated by disable bits");

  wp_force_a: assert property (
    dis_q[0] |=> wrprot_core_o)
    else $error("disable bit 0 did not force write protect");

  wp_or_a: assert property (
    !dis_q[0] && !force_wp_i && !wp_n_s |=> !wrprot_core_o)
    else $error("write protect set with no source");

  pin_input_a: assert property (
    pcfg_q[0] |=> general_pin_1_0_oe_n_o)
    else $error("input pin is being driven");

  pin_pol_a: assert property (
    pcfg_q[2:0] == 3'b000 && !pcfg_q[7]
    |=> general_pin_1_0_o == ($past(pdata_q) ^ $past(pcfg_q[1])))
    else $error("push-pull value wrong");

  pin_alt_a: assert property (
    !pcfg_q[2] |=> joystick1_button1_o)
    else $error("button active without alternate function");

  pin_od_a: assert property (
    pin_drive && pcfg_q[7] |=> !general_pin_1_0_o)
    else $error("open drain drove high");

endmodule : rdg_regs
`default_nettype wire

// file: tb/rdg_regs_bench.sv
// self-checking bench for the disable, fifo mirror and pin 1.0 registers
// assumes a single-slave ahb-lite bus with hready tied to hreadyout
`timescale 1ns/1ps
`default_nettype none
module rdg_regs_bench;
  import rdg_pkg::*;
  // ----------------------------------------
  // stimulus signals
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic fcr_load = 1'b0;
  logic [7:0] fcr_data = '0;
  logic [1:0] lock_cfg = '0;
  logic lock_pin = 1'b0;
  logic [N_FN-1:0] act = '0;
  logic fwp = 1'b0;
  logic ds0_n = 1'b1;
  logic ds1_n = 1'b1;
  logic wp_n = 1'b1;
  logic pin_in = 1'b0;
  logic look = 1'b0;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic [N_FN-1:0] fn_enable_o;
  logic wrprot_o, pin_o, oe_n_o, joy_o;
  logic [35:0] exp_q[$];
  logic [35:0] note;
  logic [7:0] v, dis, c;
  int err_total = 0;
  int samples_checked = 0;
  int ok;
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  rdg_regs i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
    .hready_i(hreadyout_o), .hwdata_i(hwdata), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .fcr_load_i(fcr_load),
    .fcr_data_i(fcr_data), .lock_cfg_i(lock_cfg),
    .lock_control_pin_i(lock_pin), .activate_i(act),
    .fn_enable_o(fn_enable_o), .force_wp_i(fwp),
    .drive_select0_n_i(ds0_n), .drive_select1_n_i(ds1_n),
    .write_protect_n_i(wp_n), .wrprot_core_o(wrprot_o),
    .general_pin_1_0_i(pin_in), .general_pin_1_0_o(pin_o),
    .general_pin_1_0_oe_n_o(oe_n_o), .joystick1_button1_o(joy_o));
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // selector 0 is read data; others are side outputs
  function automatic logic [31:0] pick(input logic [3:0] s);
    case (s)
      4'h1: return {27'h0, fn_enable_o};
      4'h2: return {31'h0, wrprot_o};
      4'h3: return {29'h0, pin_o, oe_n_o, joy_o};
      4'h4: return {30'h0, oe_n_o, joy_o};
      4'h5: return {30'h0, hresp_o, hreadyout_o};
      default: return hrdata_o;
    endcase
  endfunction : pick
  // monitor takes the oldest note whenever a result is due
  always @(posedge clk_i)
    if (look && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      chk(pick(note[35:32]), note[31:0]);
    end
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  // one whole-word transfer; a read notes its expected data
  task bus(input logic w, input logic [9:0] a, input logic [7:0] d,
           input logic [7:0] e);
    htrans <= 2'b10;
    haddr <= {22'h0, a};
    hwrite <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    if (!w)
    begin
      exp_q.push_back({4'h0, 24'h0, e});
      look <= 1'b1;
    end
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    look <= 1'b0;
  endtask : bus
  // side output check; an idle edge first keeps look single-driven
  task probe(input logic [3:0] s, input logic [31:0] e);
    @(posedge clk_i);
    exp_q.push_back({s, e});
    look <= 1'b1;
    @(posedge clk_i);
    look <= 1'b0;
  endtask : probe
  task reset_seq;
    nrst_i <= 1'b0;
    wt(8);
    nrst_i <= 1'b1;
    @(posedge clk_i);
  endtask : reset_seq
  task summarize;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // watchdog: the tests need under six hundred cycles
  // ----------------------------------------
  initial
  begin
    #400000;
    err_total++;
    summarize();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h9c67));
    reset_seq();
    bus(0, ADDR_DIS, 8'h00, 8'h00);
    bus(0, ADDR_PIN_CFG, 8'h00, 8'h01);
    bus(0, 10'h100, 8'h00, 8'h00);
    probe(4'h5, 32'h1);
    // mirror follows each captured byte, bus writes bounce off
    repeat (3)
    begin
      v = 8'($urandom);
      fcr_data <= v;
      fcr_load <= 1'b1;
      @(posedge clk_i);
      fcr_load <= 1'b0;
      bus(1, ADDR_MIRROR, ~v, 8'h00);
      bus(0, ADDR_MIRROR, 8'h00, v & 8'hCF);
    end
    // each override bit alone, then random mixes
    for (int i = 0; i < 10; i++)
    begin
      v = (i < 5) ? (8'h08 << i) : 8'($urandom);
      act <= 5'($urandom);
      bus(1, ADDR_DIS, v, 8'h00);
      bus(0, ADDR_DIS, 8'h00, v & 8'hF9);
      probe(4'h1, {27'h0, act & ~v[7:3]});
    end
    // lock table: field, pin level and whether the write lands
    dis = v & 8'hF9;
    for (int i = 0; i < 5; i++)
    begin
      lock_cfg <= (i < 2) ? 2'b01 : (i == 2) ? 2'b00 : 2'(i - 1);
      lock_pin <= (i != 1);
      ok = (i != 0);
      wt(4);
      v = 8'($urandom);
      bus(1, ADDR_DIS, v, 8'h00);
      if (ok)
        dis = v & 8'hF9;
      bus(0, ADDR_DIS, 8'h00, dis);
    end
    // every write protect input combination, override off then on
    for (int i = 0; i < 32; i++)
    begin
      if (i % 16 == 0)
        bus(1, ADDR_DIS, {7'h0, i[4]}, 8'h00);
      {ds0_n, ds1_n, wp_n, fwp} <= i[3:0];
      wt(4);
      probe(4'h2, {31'h0, (i[3] & i[0]) | (i[2] & i[0]) | i[1] | i[4]});
    end
    // pin 1.0 random configurations
    for (int i = 0; i < 16; i++)
    begin
      c = 8'($urandom);
      v = 8'($urandom);
      bus(1, ADDR_PIN_CFG, c, 8'h00);
      bus(0, ADDR_PIN_CFG, 8'h00, c & 8'h87);
      bus(1, ADDR_PIN_DATA, v, 8'h00);
      pin_in <= v[1];
      wt(4);
      if (c[2] || c[0])
        probe(4'h4, {30'h0, 1'b1, c[2] ? v[1] ^ c[1] : 1'b1});
      else if (c[7])
        probe(4'h3, {29'h0, 1'b0, v[0] ^ c[1], 1'b1});
      else
        probe(4'h3, {29'h0, v[0] ^ c[1], 1'b0, 1'b1});
      bus(0, ADDR_PIN_DATA, 8'h00, {7'h0, v[1] ^ c[1]});
    end
    // second reset in mid-run restores defaults
    reset_seq();
    bus(0, ADDR_DIS, 8'h00, 8'h00);
    bus(0, ADDR_PIN_CFG, 8'h00, 8'h01);
    probe(4'h4, 32'h3);
    wt(3);
    summarize();
  end
endmodule : rdg_regs_bench
`default_nettype wire
